// File: opc_pkg.sv
package opc_pkg;

   // ---------------------------------------------------------------
   // Widths, reset values and status bit position
   // ---------------------------------------------------------------
   localparam int TEMP_W = 8;
   localparam int VOLT_W = 8;
   localparam logic [7:0] OP_POINT_RST = 8'h00;
   // Core-rail low limit reset value; software reprograms it
   localparam logic [7:0] CORE_LOW_LIMIT_RST = 8'h00;
   // Bit of the first status register that flags a low core rail
   localparam int STATUS_CORE_LOW_BIT = 1;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic core_low_guard_enable;
      logic remote1_capture_on_overtemp;
      logic local_capture_on_overtemp;
   } opc_cfg_t;

   typedef struct packed {
      logic [TEMP_W-1:0] remote1;
      logic [TEMP_W-1:0] local_t;
   } opc_temps_t;

endpackage

// File: opc_ctrl.sv
`timescale 1ns/1ps
// Contract
// - With the guard set, standby power plus a core rail below its low limit suspends processor-hot monitoring and dynamic start-temperature control until the rail recovers.
// - While that guarded condition holds, status bit 1 of the first status register is set.
// - While that guarded condition holds, the alert output is asserted if its alert enable is on.
// - While that guarded condition holds, entry to shutdown is blocked, and it returns once the rail recovers.
// - With remote-1 capture on, an asserted overtemperature pin copies the remote-1 reading into its operating point.
// - With remote-1 capture off, the pin is ignored and the remote-1 operating point keeps its programmed value.
// - With local capture on, an asserted overtemperature pin copies the local reading into its operating point.
// - With local capture off, the pin is ignored and the local operating point keeps its programmed value.
module opc_ctrl (
   input wire logic mclk, // 20 MHz clock
   input wire logic reset_n, // Synchronous reset, active low
   input wire opc_pkg::opc_cfg_t cfg, // Guard and capture enables
   input wire logic on_standby_power, // Running from standby supply
   input wire logic [7:0] core_supply_voltage, // Latest core-rail reading
   input wire logic [7:0] core_low_limit, // Core-rail low limit
   input wire logic core_low_alert_enable, // Alert enable for this event
   input wire logic processor_hot_enable, // Processor-hot monitoring requested
   input wire logic fan_start_dynamic_enable, // Dynamic start-temperature requested
   input wire logic shutdown_request, // Request to enter shutdown
   input wire logic overtemp_pin, // Overtemperature pin, high = asserted
   input wire logic conv_done, // Pulse: a conversion has finished
   input wire opc_pkg::opc_temps_t temps_now, // Raw results of the running conversion
   input wire logic op_write, // Pulse: software writes operating points
   input wire opc_pkg::opc_temps_t op_wdata, // Software operating-point values
   output opc_pkg::opc_temps_t op_point, // Operating-point registers
   output logic status_core_low, // Status register 1 bit 1
   output logic smbalert, // Alert output, high = asserted
   output logic processor_hot_active, // Processor-hot monitoring running
   output logic fan_start_dynamic_active, // Dynamic start-temperature running
   output logic shutdown_enter // Shutdown entry permitted and requested
);

   // ---------------------------------------------------------------
   // Core-rail guard
   // ---------------------------------------------------------------
   logic core_low_reg;
   logic core_low_next;

   // Strictly below the limit; a rail sitting at the limit counts as healthy
   always_comb begin
      core_low_next = cfg.core_low_guard_enable && on_standby_power &&
                      (core_supply_voltage < core_low_limit);
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         core_low_reg <= 1'h0;
      end else begin
         core_low_reg <= core_low_next;
      end
   end

   // ---------------------------------------------------------------
   // Guarded outputs
   // ---------------------------------------------------------------

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         status_core_low <= 1'h0;
      end else begin
         status_core_low <= core_low_reg;
      end
   end

   // Alert is a plain level: it drops as soon as the rail recovers
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         smbalert <= 1'h0;
      end else begin
         smbalert <= core_low_reg && core_low_alert_enable;
      end
   end

   // Suspended functions pick up again on their own once the rail is back
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         processor_hot_active <= 1'h0;
         fan_start_dynamic_active <= 1'h0;
      end else begin
         processor_hot_active <= processor_hot_enable && !core_low_reg;
         fan_start_dynamic_active <= fan_start_dynamic_enable && !core_low_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         shutdown_enter <= 1'h0;
      end else begin
         // Holding off shutdown keeps the monitor alive while the rail sags
         shutdown_enter <= shutdown_request && !core_low_reg;
      end
   end

   // ---------------------------------------------------------------
   // Overtemperature capture
   // ---------------------------------------------------------------
   logic pin_reg;
   logic pin_rise;
   logic remote1_hit;
   logic local_hit;
   opc_pkg::opc_temps_t latest_reg;

   // Both channels decode a capture the same way; only the enable differs
   function automatic logic capture_hit(input logic rise, input logic enable);
      capture_hit = rise && enable;
   endfunction

   // Capture uses the last finished conversion, never a half-done one
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         latest_reg <= '0;
      end else if (conv_done) begin
         latest_reg <= temps_now;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pin_reg <= 1'h0;
      end else begin
         pin_reg <= overtemp_pin;
      end
   end

   assign pin_rise = overtemp_pin && !pin_reg;
   assign remote1_hit = capture_hit(pin_rise, cfg.remote1_capture_on_overtemp);
   assign local_hit = capture_hit(pin_rise, cfg.local_capture_on_overtemp);

   // Capture on the same edge wins over a software write
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         op_point <= {opc_pkg::OP_POINT_RST, opc_pkg::OP_POINT_RST};
      end else begin
         if (remote1_hit) begin
            op_point.remote1 <= latest_reg.remote1;
         end else if (op_write) begin
            op_point.remote1 <= op_wdata.remote1;
         end
         if (local_hit) begin
            op_point.local_t <= latest_reg.local_t;
         end else if (op_write) begin
            op_point.local_t <= op_wdata.local_t;
         end
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // Guard outputs trail the core-low condition by two edges and their enables by one
   guard_status_a: assert property (core_low_next |=> ##1 status_core_low)
      else $error("status bit missed core-low condition");
   status_clear_a: assert property (!core_low_next |=> ##1 !status_core_low)
      else $error("status bit stuck after recovery");
   guard_alert_a: assert property ($past(core_low_reg) && !$past(core_low_alert_enable)
      |-> !smbalert)
      else $error("alert raised while disabled");
   alert_raise_a: assert property (core_low_reg && core_low_alert_enable |=> smbalert)
      else $error("alert not raised");
   alert_clear_a: assert property (!core_low_reg |=> !smbalert)
      else $error("alert raised without core-low");
   guard_processor_hot_monitor_a: assert property (core_low_next |=> ##1 !processor_hot_active)
      else $error("processor-hot not suspended");
   guard_dyn_a: assert property (core_low_next |=> ##1 !fan_start_dynamic_active)
      else $error("dynamic control not suspended");
   resume_processor_hot_monitor_a: assert property (!core_low_next && processor_hot_enable
      ##1 processor_hot_enable |=> processor_hot_active)
      else $error("processor-hot not resumed");
   resume_dyn_a: assert property (!core_low_next && fan_start_dynamic_enable
      ##1 fan_start_dynamic_enable |=> fan_start_dynamic_active)
      else $error("dynamic control not resumed");
   processor_hot_monitor_off_a: assert property (!processor_hot_enable |=> !processor_hot_active)
      else $error("processor-hot running unrequested");
   dyn_off_a: assert property (!fan_start_dynamic_enable |=> !fan_start_dynamic_active)
      else $error("dynamic control running unrequested");
   guard_shutdown_a: assert property (core_low_reg |=> !shutdown_enter)
      else $error("shutdown entered under core-low");
   shutdown_pass_a: assert property (!core_low_next && shutdown_request
      ##1 shutdown_request |=> shutdown_enter)
      else $error("shutdown not restored after recovery");
   shutdown_idle_a: assert property (!shutdown_request |=> !shutdown_enter)
      else $error("shutdown entered unrequested");

   // Capture checks
   remote_capture_a: assert property (pin_rise && cfg.remote1_capture_on_overtemp
      |=> op_point.remote1 == $past(latest_reg.remote1))
      else $error("remote-1 capture missed");
   remote_hold_a: assert property (!cfg.remote1_capture_on_overtemp && !op_write
      |=> $stable(op_point.remote1))
      else $error("remote-1 operating point changed");
   remote_write_a: assert property (!cfg.remote1_capture_on_overtemp && op_write
      |=> op_point.remote1 == $past(op_wdata.remote1))
      else $error("remote-1 write lost while capture off");
   local_capture_a: assert property (pin_rise && cfg.local_capture_on_overtemp
      |=> op_point.local_t == $past(latest_reg.local_t))
      else $error("local capture missed");
   local_hold_a: assert property (!cfg.local_capture_on_overtemp && !op_write
      |=> $stable(op_point.local_t))
      else $error("local operating point changed");
   local_write_a: assert property (!cfg.local_capture_on_overtemp && op_write
      |=> op_point.local_t == $past(op_wdata.local_t))
      else $error("local write lost while capture off");
   // Checked one edge late: the rising edge itself captures legitimately
   one_capture_a: assert property (overtemp_pin ##1 overtemp_pin && !op_write
      |=> $stable(op_point))
      else $error("second capture in one assertion");
   quiet_hold_a: assert property (!pin_rise && !op_write |=> $stable(op_point))
      else $error("operating point changed with no capture or write");
   conv_sample_a: assert property (conv_done |=> latest_reg == $past(temps_now))
      else $error("finished conversion not kept");
   conv_hold_a: assert property (!conv_done |=> $stable(latest_reg))
      else $error("kept conversion changed between conversions");

   guard_cover_c: cover property (core_low_next ##2 status_core_low);
   remote_cover_c: cover property (pin_rise && cfg.remote1_capture_on_overtemp);
   local_cover_c: cover property (pin_rise && cfg.local_capture_on_overtemp);
   resume_cover_c: cover property (core_low_reg ##1 !core_low_reg);
   clash_cover_c: cover property (pin_rise && op_write);

endmodule

// File: opc_pin_model.sv
`timescale 1ns/1ps
// Raises the overtemperature pin for hold cycles when go is seen
module opc_pin_model (
   input wire logic mclk, // System clock
   input wire logic go, // Request one assertion
   input wire logic [3:0] hold, // Cycles the pin stays high
   output logic overtemp_pin // Pin level, high = asserted
);
   logic [3:0] left_reg = 4'h0;
   logic go_s;
   initial overtemp_pin = 1'b0;
   // A new request is only taken once the pin has been low for a cycle
   always @(posedge mclk) begin
      go_s = go;
      #1;
      if (go_s && left_reg == 4'h0 && !overtemp_pin) left_reg = hold;
      else if (left_reg != 4'h0) left_reg = left_reg - 4'h1;
      overtemp_pin = (left_reg != 4'h0);
   end
endmodule

// File: tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
   logic mclk = 0, reset_n = 0, sb = 0, ae = 0, ph_en = 1, dy_en = 1, sd_req = 1;
   logic go = 0, cd = 0, opw = 0, obs = 0, c, st, al, pa, fa, se, pin;
   logic [7:0] volt = 8'h00, lim = 8'h00;
   logic [3:0] hold = 4'h3;
   opc_pkg::opc_cfg_t cfg = '0;
   opc_pkg::opc_temps_t tn = '0, wd = '0, t1, w, ep, opp;
   logic [20:0] q[$];
   logic [20:0] e;
   wire [20:0] got = {opp, st, al, pa, fa, se};
   int n_fail = 0, tests_run = 0;
   integer seed = 32'hf401a8a2;
   always #25 mclk = ~mclk;
   opc_ctrl i_dut (.mclk(mclk), .reset_n(reset_n), .cfg(cfg), .on_standby_power(sb),
      .core_supply_voltage(volt), .core_low_limit(lim), .core_low_alert_enable(ae),
      .processor_hot_enable(ph_en), .fan_start_dynamic_enable(dy_en),
      .shutdown_request(sd_req), .overtemp_pin(pin), .conv_done(cd), .temps_now(tn),
      .op_write(opw), .op_wdata(wd), .op_point(opp), .status_core_low(st), .smbalert(al),
      .processor_hot_active(pa), .fan_start_dynamic_active(fa), .shutdown_enter(se));
   opc_pin_model i_pin (.mclk(mclk), .go(go), .hold(hold), .overtemp_pin(pin));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task chk(input logic [20:0] x);
      q.push_back(x);
      obs = 1;
      step(1);
      obs = 0;
   endtask
   task final_report;
      $display("checks=%0d fails=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(negedge mclk) begin
      if (obs) begin
         e = q.pop_front();
         `CHK(got[20:5], e[20:5])
         `CHK(got[4:0], e[4:0])
      end
   end
   // Run is about 81 cycles; this leaves ample margin
   initial begin
      #200000;
      n_fail++;
      final_report;
   end
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      step(6);
      reset_n = 1;
      wd = 16'($random(seed));
      opw = 1;
      step(1);
      opw = 0;
      step(2);
      chk({wd, 5'b00111});
      // All four capture settings; a conversion lands while the pin is
      // still high so a second capture would show up as a wrong value
      for (int i = 0; i < 4; i++) begin
         t1 = 16'($random(seed));
         tn = t1;
         cd = 1;
         step(1);
         cd = 0;
         tn = ~t1;
         w = 16'($random(seed));
         wd = w;
         opw = 1;
         cfg = opc_pkg::opc_cfg_t'(3'(i));
         step(1);
         opw = 0;
         go = 1;
         step(1);
         go = 0;
         step(1);
         tn = 16'($random(seed));
         cd = 1;
         step(1);
         cd = 0;
         step(4);
         ep = {i[1] ? t1.remote1 : w.remote1, i[0] ? t1.local_t : w.local_t};
         chk({ep, 5'b00111});
      end
      // Odd steps meet the guarded condition, even ones miss it by one term
      for (int i = 0; i < 6; i++) begin
         lim = 8'($random(seed)) | 8'h01;
         cfg = opc_pkg::opc_cfg_t'({i != 0, 2'b00});
         sb = (i != 4);
         volt = (i == 2) ? lim : lim - 8'h01;
         ae = 1'($random(seed));
         sd_req = 1'($random(seed));
         ph_en = 1'($random(seed));
         dy_en = 1'($random(seed));
         c = i[0];
         step(3);
         chk({ep, c, c & ae, ph_en & !c, dy_en & !c, sd_req & !c});
      end
      // Mid-run reset while the pin rises: the cleared pin history makes the
      // first edge after release a rise, and that capture beats the write
      cfg = opc_pkg::opc_cfg_t'(3'h2);
      reset_n = 0;
      go = 1;
      step(1);
      go = 0;
      chk(21'h0);
      w = 16'($random(seed));
      wd = w;
      opw = 1;
      reset_n = 1;
      step(1);
      opw = 0;
      step(1);
      chk({8'h00, w.local_t, 2'h0, ph_en, dy_en, sd_req});
      step(2);
      final_report;
   end
endmodule
